// *** design/agc_config_regs.sv ***
// What this block does
// - Register 01h resets to D4h, rate field starting at code 4.
// - Register 02h resets with writable fields zero; reads show forced ones.
// - Register 03h resets to E8h.
// - Reserved-high bits must be written one and always read one.
// - Reserved-low bits must be written zero and always read zero.
// - Bit 0 of register 03h is read-only; it reads zero here.
// - Register 01h bit 6 picks chained (0) or repeated readback (1).
// - Register 01h bit 5 gates oscillator output when clock-source pin high.
// - Rate code picks rate and word size; code 7 is forbidden.
// - Sample rate is a division of the master clock.
// - Register 02h bit 4 picks internal (1) or external (0) test source.
// - Register 02h bit 2 doubles the test amplitude.
// - Test period code: slow pulse, fast pulse, unused, steady level.
// - Register 03h bit 5 selects 4 V (1) or 2.4 V (0) reference.
// - Register 03h bit 3 routes amplifier input to pin or mid-supply.
// - Register 03h bit 2 powers amplifier on; zero is powered down.
`timescale 1ns/100ps
module agc_config_regs #(
  parameter int unsigned TEST_SLOW_HALF = agc_pkg::TEST_SLOW_HALF
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic wr_resv_err_o,
  input wire logic clock_source_pin_i,
  output logic readback_multi_o,
  output logic osc_clk_out_en_o,
  output logic sample_tick_o,
  output logic word_24bit_o,
  output logic rate_forbidden_o,
  output logic test_internal_o,
  output logic test_amp_double_o,
  output logic test_signal_o,
  output logic high_reference_select_o,
  output logic amp_input_route_o,
  output logic amp_power_on_o
);
  logic [7:0] cfg1_r;
  logic [7:0] cfg2_r;
  logic [7:0] cfg3_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic resv_err_r;
  logic osc_en_r;
  logic [7:0] ones_req;
  logic [7:0] wmask;
  logic addr_hit;

  agc_cfg_if cfg_bus ();

  agc_timebase #(
    .TEST_SLOW_HALF(TEST_SLOW_HALF)
  ) u_timebase (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .cfg(cfg_bus.timer)
  );

  // Reserved masks for the addressed register
  always_comb begin
    ones_req = 8'h00;
    wmask = 8'h00;
    addr_hit = 1'b1;
    unique case (reg_addr_i)
      agc_pkg::CFG1_OFS: begin
        ones_req = agc_pkg::CFG1_ONES;
        wmask = agc_pkg::CFG1_WMASK;
      end
      agc_pkg::CFG2_OFS: begin
        ones_req = agc_pkg::CFG2_ONES;
        wmask = agc_pkg::CFG2_WMASK;
      end
      agc_pkg::CFG3_OFS: begin
        ones_req = agc_pkg::CFG3_ONES;
        wmask = agc_pkg::CFG3_WMASK;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg1_r <= agc_pkg::CFG1_RST & agc_pkg::CFG1_WMASK;
    end else if (reg_wr_i && reg_addr_i == agc_pkg::CFG1_OFS) begin
      cfg1_r <= reg_wdata_i & agc_pkg::CFG1_WMASK;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg2_r <= agc_pkg::CFG2_RST & agc_pkg::CFG2_WMASK;
    end else if (reg_wr_i && reg_addr_i == agc_pkg::CFG2_OFS) begin
      cfg2_r <= reg_wdata_i & agc_pkg::CFG2_WMASK;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg3_r <= agc_pkg::CFG3_RST & agc_pkg::CFG3_WMASK;
    end else if (reg_wr_i && reg_addr_i == agc_pkg::CFG3_OFS) begin
      cfg3_r <= reg_wdata_i & agc_pkg::CFG3_WMASK;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd_i;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          agc_pkg::CFG1_OFS: rdata_r <= agc_pkg::read_view(reg_addr_i, cfg1_r);
          agc_pkg::CFG2_OFS: rdata_r <= agc_pkg::read_view(reg_addr_i, cfg2_r);
          agc_pkg::CFG3_OFS: rdata_r <= agc_pkg::read_view(reg_addr_i, cfg3_r);
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      resv_err_r <= 1'b0;
    end else begin
      resv_err_r <= reg_wr_i && addr_hit &&
                    ((reg_wdata_i & ~wmask) != ones_req);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_en_r <= 1'b0;
    end else begin
      osc_en_r <= cfg1_r[agc_pkg::OSC_OUT_BIT] && clock_source_pin_i;
    end
  end

  assign cfg_bus.sample_rate_code = cfg1_r[agc_pkg::RATE_LSB +: 3];
  assign cfg_bus.test_period_code = cfg2_r[agc_pkg::PERIOD_LSB +: 2];

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;
  assign wr_resv_err_o = resv_err_r;
  assign readback_multi_o = cfg1_r[agc_pkg::READBACK_BIT];
  assign osc_clk_out_en_o = osc_en_r;
  assign sample_tick_o = cfg_bus.sample_tick;
  assign word_24bit_o = cfg_bus.word_24bit;
  assign rate_forbidden_o = cfg_bus.rate_forbidden;
  assign test_internal_o = cfg2_r[agc_pkg::TEST_SRC_BIT];
  assign test_amp_double_o = cfg2_r[agc_pkg::TEST_AMP_BIT];
  assign test_signal_o = cfg_bus.test_level;
  assign high_reference_select_o = cfg3_r[agc_pkg::HIGH_REF_BIT];
  assign amp_input_route_o = cfg3_r[agc_pkg::AMP_ROUTE_BIT];
  assign amp_power_on_o = cfg3_r[agc_pkg::AMP_PWR_BIT];

  // Checking helpers
  logic [11:0] gap_r;
  logic armed_r;
  logic fresh_r;
  logic [2:0] code_seen_r;

  // Rate code one cycle late, marks a divider restart
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      code_seen_r <= 3'h0;
    end else begin
      code_seen_r <= cfg_bus.sample_rate_code;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_r <= 12'h000;
      armed_r <= 1'b0;
    end else if (cfg_bus.sample_rate_code != code_seen_r ||
                 (reg_wr_i && reg_addr_i == agc_pkg::CFG1_OFS)) begin
      gap_r <= 12'h000;
      armed_r <= 1'b0;
    end else if (sample_tick_o) begin
      gap_r <= 12'h001;
      armed_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 12'h001;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence seq_read(logic [7:0] ofs);
    reg_rd_i && reg_addr_i == ofs && !reg_wr_i;
  endsequence

  sequence seq_write(logic [7:0] ofs);
    reg_wr_i && reg_addr_i == ofs;
  endsequence

  chk_reset_view: assert property (fresh_r |->
      agc_pkg::read_view(agc_pkg::CFG1_OFS, cfg1_r) == agc_pkg::CFG1_RST
      && cfg1_r[agc_pkg::RATE_LSB +: 3] == 3'h4)
    else $error("first register reset view wrong");

  chk_cfg2_reset: assert property (fresh_r |->
      cfg2_r == 8'h00 && test_internal_o == 1'b0 && test_amp_double_o == 1'b0)
    else $error("second register reset fields wrong");

  chk_cfg3_reset: assert property (fresh_r |->
      agc_pkg::read_view(agc_pkg::CFG3_OFS, cfg3_r) == agc_pkg::CFG3_RST)
    else $error("third register reset view wrong");

  chk_ones_read: assert property (seq_read(agc_pkg::CFG2_OFS) ##1 reg_rvalid_o
      |-> (reg_rdata_o & agc_pkg::CFG2_ONES) == agc_pkg::CFG2_ONES)
    else $error("reserved high bits not read as one");

  chk_zeros_read: assert property (seq_read(agc_pkg::CFG1_OFS) |=>
      reg_rvalid_o && reg_rdata_o[3] == 1'b0 && reg_rdata_o[7] && reg_rdata_o[4])
    else $error("reserved bits of first register read wrong");

  chk_ro_bit: assert property (seq_write(agc_pkg::CFG3_OFS) ##1 (!reg_wr_i) [*4] ##1
      seq_read(agc_pkg::CFG3_OFS) |=> reg_rdata_o[1:0] == 2'h0 && reg_rdata_o[4] == 1'b0)
    else $error("third register low bits not zero");

  chk_readback_mode: assert property (seq_write(agc_pkg::CFG1_OFS) |=>
      readback_multi_o == $past(reg_wdata_i[agc_pkg::READBACK_BIT]))
    else $error("readback mode not taken from write");

  chk_osc_gate: assert property (##1 osc_clk_out_en_o ==
      ($past(cfg1_r[agc_pkg::OSC_OUT_BIT]) && $past(clock_source_pin_i)))
    else $error("oscillator output gate wrong");

  chk_forbid_tick: assert property ((cfg_bus.sample_rate_code == agc_pkg::RATE_FORBID) [*2]
      |-> !sample_tick_o && rate_forbidden_o && !word_24bit_o)
    else $error("forbidden rate code still runs");

  chk_word_size: assert property ($stable(cfg_bus.sample_rate_code) &&
      cfg_bus.sample_rate_code <= agc_pkg::RATE_16BIT_MAX |=> !word_24bit_o)
    else $error("16-bit rate codes report 24-bit words");

  chk_rate_period: assert property (sample_tick_o && armed_r |->
      gap_r == agc_pkg::rate_divisor(cfg_bus.sample_rate_code))
    else $error("sample strobe spacing wrong");

  chk_test_source: assert property (seq_write(agc_pkg::CFG2_OFS) |=>
      test_internal_o == $past(reg_wdata_i[agc_pkg::TEST_SRC_BIT]))
    else $error("test source not taken from write");

  chk_test_amp: assert property (seq_write(agc_pkg::CFG2_OFS) |=>
      test_amp_double_o == $past(reg_wdata_i[agc_pkg::TEST_AMP_BIT]))
    else $error("test amplitude not taken from write");

  chk_test_steady: assert property (
      (cfg_bus.test_period_code == agc_pkg::PERIOD_DC) [*2]
      |-> test_signal_o ##1 (test_signal_o || $changed(cfg_bus.test_period_code)))
    else $error("steady test level not high");

  chk_test_unused: assert property (
      (cfg_bus.test_period_code == agc_pkg::PERIOD_UNUSED) [*2] |-> !test_signal_o)
    else $error("unused test code drives a level");

  chk_high_ref: assert property (seq_write(agc_pkg::CFG3_OFS) |=>
      high_reference_select_o == $past(reg_wdata_i[agc_pkg::HIGH_REF_BIT]))
    else $error("reference select not taken from write");

  chk_amp_route: assert property (seq_write(agc_pkg::CFG3_OFS) |=>
      amp_input_route_o == $past(reg_wdata_i[agc_pkg::AMP_ROUTE_BIT]))
    else $error("amplifier route not taken from write");

  chk_amp_power: assert property (seq_write(agc_pkg::CFG3_OFS) |=>
      amp_power_on_o == $past(reg_wdata_i[agc_pkg::AMP_PWR_BIT]))
    else $error("amplifier power not taken from write");

  chk_field_hold: assert property (!reg_wr_i |=> $stable(cfg1_r)
      && $stable(cfg2_r) && $stable(cfg3_r))
    else $error("field changed without a write");

  chk_read_echo: assert property (seq_write(agc_pkg::CFG1_OFS) ##1 (!reg_wr_i) [*4] ##1
      seq_read(agc_pkg::CFG1_OFS) |=> reg_rdata_o ==
      (($past(reg_wdata_i, 6) & agc_pkg::CFG1_WMASK) | agc_pkg::CFG1_ONES))
    else $error("read does not return written value");

  chk_unmapped: assert property (reg_rd_i && reg_addr_i > agc_pkg::CFG3_OFS |=>
      reg_rvalid_o && reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");

  chk_resv_low: assert property (reg_wr_i && reg_addr_i == agc_pkg::CFG1_OFS &&
      reg_wdata_i[3] |=> wr_resv_err_o)
    else $error("reserved low bit write not flagged");

  chk_resv_high: assert property (reg_wr_i && reg_addr_i == agc_pkg::CFG2_OFS &&
      (reg_wdata_i & agc_pkg::CFG2_ONES) != agc_pkg::CFG2_ONES |=> wr_resv_err_o)
    else $error("reserved high bit write not flagged");

  chk_resv_clean: assert property (reg_wr_i && reg_addr_i == agc_pkg::CFG3_OFS &&
      (reg_wdata_i & ~agc_pkg::CFG3_WMASK) == agc_pkg::CFG3_ONES |=> !wr_resv_err_o)
    else $error("legal write flagged as reserved error");

  chk_word_wide: assert property (!fresh_r && $stable(cfg_bus.sample_rate_code) &&
      cfg_bus.sample_rate_code > agc_pkg::RATE_16BIT_MAX &&
      cfg_bus.sample_rate_code != agc_pkg::RATE_FORBID |=> word_24bit_o)
    else $error("24-bit rate codes report 16-bit words");

  chk_tick_pulse: assert property (sample_tick_o |=> !sample_tick_o)
    else $error("sample strobe longer than one cycle");

  chk_read_answer: assert property (##1 reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer not one cycle after request");

  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
endmodule

// *** inc/agc_pkg.sv ***
package agc_pkg;
  // Register offsets
  localparam logic [7:0] CFG1_OFS = 8'h01;
  localparam logic [7:0] CFG2_OFS = 8'h02;
  localparam logic [7:0] CFG3_OFS = 8'h03;
  // Reset values as read back, except CFG2_RST (writable fields only)
  localparam logic [7:0] CFG1_RST = 8'hd4;
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [7:0] CFG3_RST = 8'he8;
  // Bits forced high on read
  localparam logic [7:0] CFG1_ONES = 8'h90;
  localparam logic [7:0] CFG2_ONES = 8'he0;
  localparam logic [7:0] CFG3_ONES = 8'hc0;
  // Bits that hold written data
  localparam logic [7:0] CFG1_WMASK = 8'h67;
  localparam logic [7:0] CFG2_WMASK = 8'h17;
  localparam logic [7:0] CFG3_WMASK = 8'h2c;
  // Field positions
  localparam int READBACK_BIT = 6;
  localparam int OSC_OUT_BIT = 5;
  localparam int RATE_LSB = 0;
  localparam int TEST_SRC_BIT = 4;
  localparam int TEST_AMP_BIT = 2;
  localparam int PERIOD_LSB = 0;
  localparam int HIGH_REF_BIT = 5;
  localparam int AMP_ROUTE_BIT = 3;
  localparam int AMP_PWR_BIT = 2;
  // Field codes
  localparam logic [2:0] RATE_FORBID = 3'h7;
  localparam logic [2:0] RATE_16BIT_MAX = 3'h1;
  localparam logic [1:0] PERIOD_SLOW = 2'h0;
  localparam logic [1:0] PERIOD_FAST = 2'h1;
  localparam logic [1:0] PERIOD_UNUSED = 2'h2;
  localparam logic [1:0] PERIOD_DC = 2'h3;
  // Master clocks per sample at the fastest rate code
  localparam logic [11:0] RATE_BASE_DIV = 12'h020;
  // Master clocks per half period of the slow test signal (2^21 / 2)
  localparam int unsigned TEST_SLOW_HALF = 1048576;

  function automatic logic [11:0] rate_divisor(input logic [2:0] code);
    rate_divisor = RATE_BASE_DIV << code;
  endfunction

  function automatic logic [7:0] read_view(input logic [7:0] ofs, input logic [7:0] held);
    read_view = 8'h00;
    if (ofs == CFG1_OFS) begin
      read_view = (held & CFG1_WMASK) | CFG1_ONES;
    end else if (ofs == CFG2_OFS) begin
      read_view = (held & CFG2_WMASK) | CFG2_ONES;
    end else if (ofs == CFG3_OFS) begin
      read_view = (held & CFG3_WMASK) | CFG3_ONES;
    end
  endfunction
endpackage

// *** inc/agc_cfg_if.sv ***
`timescale 1ns/100ps
interface agc_cfg_if;
  logic [2:0] sample_rate_code;
  logic [1:0] test_period_code;
  logic sample_tick;
  logic word_24bit;
  logic rate_forbidden;
  logic test_level;
  modport regs (output sample_rate_code, output test_period_code,
                input sample_tick, input word_24bit, input rate_forbidden, input test_level);
  modport timer (input sample_rate_code, input test_period_code,
                 output sample_tick, output word_24bit, output rate_forbidden, output test_level);
endinterface

// *** design/agc_timebase.sv ***
`timescale 1ns/100ps
module agc_timebase #(
  parameter int unsigned TEST_SLOW_HALF = agc_pkg::TEST_SLOW_HALF
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  agc_cfg_if.timer cfg
);
  logic [11:0] rate_cnt_r;
  logic [2:0] rate_seen_r;
  logic tick_r;
  logic w24_r;
  logic forbid_r;
  logic [20:0] test_cnt_r;
  logic [1:0] period_seen_r;
  logic test_lvl_r;
  logic [11:0] div;
  logic [20:0] half;
  logic rate_ok;

  assign div = agc_pkg::rate_divisor(cfg.sample_rate_code);
  assign rate_ok = cfg.sample_rate_code != agc_pkg::RATE_FORBID;
  assign half = (cfg.test_period_code == agc_pkg::PERIOD_SLOW) ?
                TEST_SLOW_HALF[20:0] : TEST_SLOW_HALF[21:1];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rate_cnt_r <= 12'h000;
      rate_seen_r <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      rate_seen_r <= cfg.sample_rate_code;
      if (cfg.sample_rate_code != rate_seen_r || !rate_ok) begin
        rate_cnt_r <= 12'h000;
        tick_r <= 1'b0;
      end else if (rate_cnt_r == div - 12'h001) begin
        rate_cnt_r <= 12'h000;
        tick_r <= 1'b1;
      end else begin
        rate_cnt_r <= rate_cnt_r + 12'h001;
        tick_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      w24_r <= 1'b0;
      forbid_r <= 1'b0;
    end else begin
      w24_r <= rate_ok && cfg.sample_rate_code > agc_pkg::RATE_16BIT_MAX;
      forbid_r <= !rate_ok;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      test_cnt_r <= 21'h000000;
      period_seen_r <= 2'h0;
      test_lvl_r <= 1'b0;
    end else begin
      period_seen_r <= cfg.test_period_code;
      if (cfg.test_period_code != period_seen_r ||
          cfg.test_period_code == agc_pkg::PERIOD_DC ||
          cfg.test_period_code == agc_pkg::PERIOD_UNUSED) begin
        test_cnt_r <= 21'h000000;
        test_lvl_r <= cfg.test_period_code == agc_pkg::PERIOD_DC;
      end else if (test_cnt_r == half - 21'h000001) begin
        test_cnt_r <= 21'h000000;
        test_lvl_r <= !test_lvl_r;
      end else begin
        test_cnt_r <= test_cnt_r + 21'h000001;
      end
    end
  end

  assign cfg.sample_tick = tick_r;
  assign cfg.word_24bit = w24_r;
  assign cfg.rate_forbidden = forbid_r;
  assign cfg.test_level = test_lvl_r;
endmodule

// *** verif/agc_host_model.sv ***
`timescale 1ns/100ps
module agc_host_model (
  input wire logic clk_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end

  task automatic gap();
    repeat (3) @(posedge clk_i);
  endtask

  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d, input logic raw);
    logic [7:0] v;
    v = d;
    if (!raw) begin
      case (ofs)
        agc_pkg::CFG1_OFS: v = (d & agc_pkg::CFG1_WMASK) | agc_pkg::CFG1_ONES;
        agc_pkg::CFG2_OFS: v = (d & agc_pkg::CFG2_WMASK) | agc_pkg::CFG2_ONES;
        agc_pkg::CFG3_OFS: v = (d & agc_pkg::CFG3_WMASK) | agc_pkg::CFG3_ONES;
        default: v = d;
      endcase
    end
    @(posedge clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= ofs;
    reg_wdata_o <= v;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    // Released lines show stale inverse
    reg_addr_o <= ~ofs;
    reg_wdata_o <= ~v;
    gap();
  endtask

  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
    @(posedge clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= ofs;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~ofs;
    #1;
    ok = reg_rvalid_i;
    d = reg_rdata_i;
    gap();
  endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/100ps
module tb;
  localparam int unsigned SLOW = 16;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic pin = 1'b0;
  logic wr, rd, rvalid, err, rb_multi, osc_en, tick, w24, forbid;
  logic t_int, t_dbl, t_sig, hi_ref, route, pwr;
  logic [7:0] addr, wdata, rdata;
  logic [7:0] sh [4];
  logic [15:0] lfsr = 16'h0003;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int err_seen = 0;

  always #5 clk_i = ~clk_i;

  agc_config_regs #(.TEST_SLOW_HALF(SLOW)) agc_config_regs_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .wr_resv_err_o(err), .clock_source_pin_i(pin),
    .readback_multi_o(rb_multi), .osc_clk_out_en_o(osc_en), .sample_tick_o(tick),
    .word_24bit_o(w24), .rate_forbidden_o(forbid), .test_internal_o(t_int),
    .test_amp_double_o(t_dbl), .test_signal_o(t_sig),
    .high_reference_select_o(hi_ref), .amp_input_route_o(route),
    .amp_power_on_o(pwr)
  );

  agc_host_model agc_host_model_inst (
    .clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid)
  );

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (err === 1'b1) begin
      err_seen <= err_seen + 1;
    end
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] exp_view(input logic [7:0] ofs, input logic [7:0] d);
    case (ofs)
      8'h01: exp_view = (d & 8'h67) | 8'h90;
      8'h02: exp_view = (d & 8'h17) | 8'he0;
      8'h03: exp_view = (d & 8'h2c) | 8'hc0;
      default: exp_view = 8'h00;
    endcase
  endfunction

  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d, input logic raw);
    sh[ofs[1:0]] = d;
    agc_host_model_inst.write_reg(ofs, d, raw);
  endtask

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] got;
    logic ok;
    agc_host_model_inst.read_reg(ofs, got, ok);
    check("rvalid", 12'h001, 12'(ok));
    check("rdata", 12'(exp), 12'(got));
  endtask

  task automatic fields_chk();
    check("fields", {6'h00, rb_multi, t_int, t_dbl, hi_ref, route, pwr},
          {6'h00, sh[1][6], sh[2][4], sh[2][2], sh[3][5], sh[3][3], sh[3][2]});
  endtask

  task automatic wait_ev(input logic wave, output int n);
    logic last;
    last = t_sig;
    n = 0;
    do begin
      step();
      n++;
    end while (n < 4000 && (wave ? t_sig === last : tick !== 1'b1));
  endtask

  initial begin
    int n;
    logic [7:0] ofs;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    sh[1] = 8'hd4;
    sh[2] = 8'h00;
    sh[3] = 8'he8;
    step();
    fields_chk();
    rd_chk(8'h01, 8'hd4);
    rd_chk(8'h02, 8'he0);
    rd_chk(8'h03, 8'he8);
    rd_chk(8'h04, 8'h00);
    for (int i = 0; i < 16; i++) begin
      lfsr = lfsr_next(lfsr);
      ofs = 8'h01 + 8'(lfsr[9:8] % 2'h3);
      wr_reg(ofs, lfsr[7:0], 1'b0);
      rd_chk(ofs, exp_view(ofs, lfsr[7:0]));
      fields_chk();
    end
    check("resv_err_legal", 12'h000, 12'(err_seen));
    wr_reg(8'h03, 8'hff, 1'b1);
    rd_chk(8'h03, 8'hec);
    wr_reg(8'h01, 8'h08, 1'b1);
    rd_chk(8'h01, 8'h90);
    wr_reg(8'h02, 8'h00, 1'b1);
    rd_chk(8'h02, 8'he0);
    fields_chk();
    check("resv_err_bad", 12'h003, 12'(err_seen));
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'h01, 8'h44 | (k[1] ? 8'h20 : 8'h00), 1'b0);
      @(posedge clk_i);
      pin <= k[0];
      repeat (3) step();
      check("osc_en", 12'(k[1] & k[0]), 12'(osc_en));
    end
    for (int c = 0; c < 7; c++) begin
      wr_reg(8'h01, 8'h40 | 8'(c), 1'b0);
      wait_ev(1'b0, n);
      wait_ev(1'b0, n);
      check("tick_period", 12'(32 << c), 12'(n));
      check("word_24bit", 12'(c >= 2), 12'(w24));
      check("forbidden", 12'h000, 12'(forbid));
    end
    wr_reg(8'h01, 8'h47, 1'b0);
    wait_ev(1'b0, n);
    check("forbidden", 12'h001, 12'(forbid));
    check("no_tick", 12'd4000, 12'(n));
    for (int p = 0; p < 2; p++) begin
      wr_reg(8'h02, 8'h10 | 8'(p), 1'b0);
      wait_ev(1'b1, n);
      wait_ev(1'b1, n);
      check("test_half", 12'(SLOW >> p), 12'(n));
    end
    wr_reg(8'h02, 8'h13, 1'b0);
    repeat (3) step();
    check("test_dc", 12'h001, 12'(t_sig));
    wr_reg(8'h02, 8'h12, 1'b0);
    repeat (3) step();
    check("test_unused", 12'h000, 12'(t_sig));
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd_chk(8'h01, 8'hd4);
    rd_chk(8'h02, 8'he0);
    rd_chk(8'h03, 8'he8);
    sh[1] = 8'hd4;
    sh[2] = 8'h00;
    sh[3] = 8'he8;
    fields_chk();
    check("word_24bit", 12'h001, 12'(w24));
    give_verdict();
  end
endmodule
